// ---- inc/fws_map.svh ----
`ifndef FWS_MAP_SVH
`define FWS_MAP_SVH
// software register offsets (word index on the command port)
`define FWS_REG_CTRL     4'h0
`define FWS_REG_ADDR     4'h1
`define FWS_REG_DATA     4'h2
`define FWS_REG_STATUS   4'h3
`define FWS_REG_RESULT   4'h4
// control register fields
`define FWS_CTRL_GO      0
`define FWS_CTRL_OP_LO   1
`define FWS_CTRL_OP_HI   3
// status register fields
`define FWS_ST_BUSY      0
`define FWS_ST_DONE      1
`define FWS_ST_FAIL      2
`define FWS_ST_RDY       3
`define FWS_ST_TIMER     4
`define FWS_ST_SUSP      5
// flash data bit positions
`define FWS_POLL_BIT     7
`define FWS_TOG1_BIT     6
`define FWS_TOUT_BIT     5
`define FWS_ETMR_BIT     3
`define FWS_TOG2_BIT     2
// command words of the flash command set
`define FWS_UNLOCK_A1    24'h00_0555
`define FWS_UNLOCK_D1    16'h0000_00AA
`define FWS_UNLOCK_A2    24'h00_02AA
`define FWS_UNLOCK_D2    16'h0000_0055
`define FWS_CMD_PROG     16'h0000_00A0
`define FWS_CMD_ERASE    16'h0000_0080
`define FWS_CMD_CHIP     16'h0000_0010
`define FWS_CMD_SECT     16'h0000_0030
`define FWS_CMD_SUSP     16'h0000_00B0
`define FWS_CMD_RESUME   16'h0000_0030
`define FWS_CMD_RESET    16'h0000_00F0
// bus phase timing: 90 ns access at 8 ns clock, rounded up
`define FWS_T_ACC_NS     90
`define FWS_T_CLK_NS     8
`define FWS_ACC_CYC      ((`FWS_T_ACC_NS + `FWS_T_CLK_NS - 1) / `FWS_T_CLK_NS)
// limit on polling reads before the host gives up
`define FWS_POLL_LIMIT   32'd1000000
`endif

// ---- inc/fws_pkg.sv ----
package fws_pkg;
   // operation codes written into the control register
   typedef enum logic [2:0] {
      FWS_OP_PROG   = 3'h0,
      FWS_OP_SECT   = 3'h1,
      FWS_OP_CHIP   = 3'h2,
      FWS_OP_SUSP   = 3'h3,
      FWS_OP_RESUME = 3'h4,
      FWS_OP_RESET  = 3'h5,
      FWS_OP_READ   = 3'h6
   } fws_op_e;
   // one flash bus cycle request
   typedef struct packed {
      logic        wr;
      logic [23:0] addr;
      logic [15:0] data;
   } fws_cyc_s;
   // decoded status bits of one read
   typedef struct packed {
      logic poll;
      logic tog1;
      logic tout;
      logic etmr;
      logic tog2;
   } fws_stat_s;
endpackage

// ---- hdl/fws_bus_cycle.sv ----
`timescale 1ns/1ps
`include "fws_map.svh"
// one flash bus cycle: chip select and strobe held for the access time
module fws_bus_cycle
   import fws_pkg::*;
#(
   parameter int ACC_CYC = `FWS_ACC_CYC
) (
   // system
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        ce,
   // request side
   input  wire logic        start,
   input  wire fws_cyc_s    cyc,
   output logic             done,
   output logic [15:0]      rdata,
   // flash pins
   output logic             chip_select_n,
   output logic             output_enable_n,
   output logic             write_strobe_n,
   output logic [23:0]      flash_addr,
   output logic [15:0]      flash_dq_out,
   output logic             flash_dq_oe,
   input  wire logic [15:0] flash_dq_in
);
   initial begin
      if (ACC_CYC < 1 || ACC_CYC > 255) $error("ACC_CYC out of range");
   end
   logic [7:0]  cnt_reg, cnt_next;
   logic        act_reg, act_next, wr_reg, wr_next, done_reg, done_next;
   logic        cs_n_reg, cs_n_next, oe_n_reg, oe_n_next, we_n_reg, we_n_next;
   logic        dqoe_reg, dqoe_next;
   logic [23:0] addr_reg, addr_next;
   logic [15:0] wd_reg, wd_next, rd_reg, rd_next;
   // next state: strobe stays low for ACC_CYC cycles, data sampled at the end
   always_comb begin
      cnt_next  = cnt_reg;
      act_next  = act_reg;
      wr_next   = wr_reg;
      addr_next = addr_reg;
      wd_next   = wd_reg;
      rd_next   = rd_reg;
      done_next = 1'b0;
      if (!act_reg && start) begin
         act_next  = 1'b1;
         cnt_next  = 8'h00;
         wr_next   = cyc.wr;
         addr_next = cyc.addr;
         wd_next   = cyc.data;
      end else if (act_reg) begin
         if (cnt_reg == ACC_CYC[7:0] - 8'h01) begin
            act_next  = 1'b0;
            done_next = 1'b1; // strobe rises here, latching the write
            if (!wr_reg) rd_next = flash_dq_in;
         end else begin
            cnt_next = cnt_reg + 8'h01;
         end
      end
      // pins follow the next activity so that each leaves a flip-flop directly
      cs_n_next = ~act_next;
      oe_n_next = ~(act_next & ~wr_next);
      we_n_next = ~(act_next & wr_next);
      dqoe_next = act_next & wr_next;
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg  <= 8'h00;
         act_reg  <= 1'b0;
         wr_reg   <= 1'b0;
         addr_reg <= 24'h00_0000;
         wd_reg   <= 16'h0000;
         rd_reg   <= 16'h0000;
         done_reg <= 1'b0;
         cs_n_reg <= 1'b1;
         oe_n_reg <= 1'b1;
         we_n_reg <= 1'b1;
         dqoe_reg <= 1'b0;
      end else if (ce) begin
         cnt_reg  <= cnt_next;
         act_reg  <= act_next;
         wr_reg   <= wr_next;
         addr_reg <= addr_next;
         wd_reg   <= wd_next;
         rd_reg   <= rd_next;
         done_reg <= done_next;
         cs_n_reg <= cs_n_next;
         oe_n_reg <= oe_n_next;
         we_n_reg <= we_n_next;
         dqoe_reg <= dqoe_next;
      end
   end
   assign done            = done_reg;
   assign rdata           = rd_reg;
   assign chip_select_n   = cs_n_reg;
   assign output_enable_n = oe_n_reg;
   assign write_strobe_n  = we_n_reg;
   assign flash_addr      = addr_reg;
   assign flash_dq_out    = wd_reg;
   assign flash_dq_oe     = dqoe_reg;
endmodule

// ---- hdl/fws_seq_rom.sv ----
`timescale 1ns/1ps
`include "fws_map.svh"
// command sequence table: cycle step of each operation
module fws_seq_rom
   import fws_pkg::*;
(
   // lookup
   input  wire fws_op_e     op,
   input  wire logic [2:0]  step,
   input  wire logic [23:0] addr,
   input  wire logic [15:0] data,
   output fws_cyc_s         cyc,
   output logic [2:0]       len
);
   // unlock pairs lead every program and erase sequence
   always_comb begin
      cyc = '{wr: 1'b1, addr: addr, data: `FWS_CMD_RESET};
      len = 3'd1;
      case (op)
         FWS_OP_PROG: begin
            len = 3'd4;
            case (step)
               3'd0: cyc = '{1'b1, `FWS_UNLOCK_A1, `FWS_UNLOCK_D1};
               3'd1: cyc = '{1'b1, `FWS_UNLOCK_A2, `FWS_UNLOCK_D2};
               3'd2: cyc = '{1'b1, `FWS_UNLOCK_A1, `FWS_CMD_PROG};
               default: cyc = '{1'b1, addr, data};
            endcase
         end
         FWS_OP_SECT, FWS_OP_CHIP: begin
            len = 3'd6;
            case (step)
               3'd0, 3'd3: cyc = '{1'b1, `FWS_UNLOCK_A1, `FWS_UNLOCK_D1};
               3'd1, 3'd4: cyc = '{1'b1, `FWS_UNLOCK_A2, `FWS_UNLOCK_D2};
               3'd2: cyc = '{1'b1, `FWS_UNLOCK_A1, `FWS_CMD_ERASE};
               default: begin
                  if (op == FWS_OP_SECT) cyc = '{1'b1, addr, `FWS_CMD_SECT};
                  else cyc = '{1'b1, `FWS_UNLOCK_A1, `FWS_CMD_CHIP};
               end
            endcase
         end
         FWS_OP_SUSP:   cyc = '{1'b1, addr, `FWS_CMD_SUSP};
         FWS_OP_RESUME: cyc = '{1'b1, addr, `FWS_CMD_RESUME};
         FWS_OP_READ:   cyc = '{1'b0, addr, 16'h0000};
         default:       cyc = '{1'b1, addr, `FWS_CMD_RESET};
      endcase
   end
endmodule

// ---- hdl/fws_host.sv ----
`timescale 1ns/1ps
`include "fws_map.svh"
module fws_host
   import fws_pkg::*;
#(
   parameter int ACC_CYC    = `FWS_ACC_CYC,
   parameter int POLL_LIMIT = `FWS_POLL_LIMIT
) (
   // system
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        ce,
   // software command port
   input  wire logic [3:0]  sw_addr,
   input  wire logic [31:0] sw_wdata,
   input  wire logic        sw_wr,
   input  wire logic        sw_rd,
   output logic [31:0]      sw_rdata,
   // flash pins
   output logic             chip_select_n,
   output logic             output_enable_n,
   output logic             write_strobe_n,
   output logic [23:0]      flash_addr,
   output logic [15:0]      flash_dq_out,
   output logic             flash_dq_oe,
   input  wire logic [15:0] flash_dq_in,
   input  wire logic        ready_busy_n
);
   initial begin
      if (POLL_LIMIT < 2) $error("POLL_LIMIT too small");
   end
   typedef enum logic [5:0] {
      FWS_S_IDLE  = 6'b00_0001,
      FWS_S_SEQ   = 6'b00_0010,
      FWS_S_RD1   = 6'b00_0100,
      FWS_S_RD2   = 6'b00_1000,
      FWS_S_FINAL = 6'b01_0000,
      FWS_S_RST   = 6'b10_0000
   } fws_state_e;
   fws_state_e  st_reg, st_next;
   fws_op_e     op_reg, op_next, rom_op;
   logic [2:0]  step_reg, step_next, rom_len;
   logic [23:0] addr_reg, addr_next;
   logic [15:0] data_reg, data_next, res_reg, res_next, prev_reg, prev_next, rdata;
   logic        done_reg, done_next, fail_reg, fail_next, recheck_reg, recheck_next;
   logic        susp_reg, susp_next, etmr_reg, etmr_next;
   logic [31:0] polls_reg, polls_next, rd_out_reg, rd_out_next;
   logic        cyc_start, cyc_done;
   fws_cyc_s    rom_cyc, cyc;
   fws_stat_s   now_s;

   assign rom_op = (st_reg == FWS_S_RST) ? FWS_OP_RESET : op_reg;
   fws_seq_rom u_rom (
      .op   (rom_op),
      .step (step_reg),
      .addr (addr_reg),
      .data (data_reg),
      .cyc  (rom_cyc),
      .len  (rom_len)
   );
   // status polls are plain reads at the operation's target address
   assign cyc = (st_reg == FWS_S_SEQ || st_reg == FWS_S_RST) ? rom_cyc
              : '{wr: 1'b0, addr: addr_reg, data: 16'h0000};
   fws_bus_cycle #(.ACC_CYC(ACC_CYC)) u_bus (
      .clk             (clk),
      .resetn          (resetn),
      .ce              (ce),
      .start           (cyc_start),
      .cyc             (cyc),
      .done            (cyc_done),
      .rdata           (rdata),
      .chip_select_n   (chip_select_n),
      .output_enable_n (output_enable_n),
      .write_strobe_n  (write_strobe_n),
      .flash_addr      (flash_addr),
      .flash_dq_out    (flash_dq_out),
      .flash_dq_oe     (flash_dq_oe),
      .flash_dq_in     (flash_dq_in)
   );
   // decoded view of the word just read
   assign now_s = '{poll: rdata[`FWS_POLL_BIT], tog1: rdata[`FWS_TOG1_BIT],
                    tout: rdata[`FWS_TOUT_BIT], etmr: rdata[`FWS_ETMR_BIT],
                    tog2: rdata[`FWS_TOG2_BIT]};
   logic busy_st, go;
   assign busy_st   = (st_reg != FWS_S_IDLE);
   assign go        = sw_wr && sw_addr == `FWS_REG_CTRL && sw_wdata[`FWS_CTRL_GO] && !busy_st;
   // a new bus cycle is launched one cycle after the previous completes
   logic launch_reg, launch_next;
   assign cyc_start = launch_reg;

   // sequencer next state
   always_comb begin
      st_next      = st_reg;
      op_next      = op_reg;
      step_next    = step_reg;
      addr_next    = addr_reg;
      data_next    = data_reg;
      res_next     = res_reg;
      prev_next    = prev_reg;
      done_next    = done_reg;
      fail_next    = fail_reg;
      recheck_next = recheck_reg;
      susp_next    = susp_reg;
      etmr_next    = etmr_reg;
      polls_next   = polls_reg;
      launch_next  = 1'b0;
      if (sw_wr && sw_addr == `FWS_REG_ADDR && !busy_st) addr_next = sw_wdata[23:0];
      if (sw_wr && sw_addr == `FWS_REG_DATA && !busy_st) data_next = sw_wdata[15:0];
      case (st_reg)
         FWS_S_IDLE: begin
            if (go) begin
               op_next      = fws_op_e'(sw_wdata[`FWS_CTRL_OP_HI:`FWS_CTRL_OP_LO]);
               step_next    = 3'd0;
               done_next    = 1'b0;
               fail_next    = 1'b0;
               recheck_next = 1'b0;
               etmr_next    = 1'b0;
               polls_next   = 32'h0000_0000;
               launch_next  = 1'b1;
               st_next      = (op_next == FWS_OP_READ) ? FWS_S_FINAL : FWS_S_SEQ;
            end
         end
         FWS_S_SEQ: begin
            if (cyc_done) begin
               launch_next = 1'b1;
               if (step_reg == rom_len - 3'd1) begin
                  // status valid only after the last write's rising edge
                  step_next = 3'd0;
                  case (op_reg)
                     FWS_OP_SUSP:   begin susp_next = 1'b1; st_next = FWS_S_RD1; end
                     FWS_OP_RESUME: begin susp_next = 1'b0; st_next = FWS_S_RD1; end
                     FWS_OP_RESET:  begin susp_next = 1'b0; st_next = FWS_S_FINAL; end
                     default:       st_next = FWS_S_RD1;
                  endcase
               end else begin
                  step_next = step_reg + 3'd1;
               end
            end
         end
         FWS_S_RD1: begin
            if (cyc_done) begin
               prev_next   = rdata;
               launch_next = 1'b1;
               // sector erase start shows on erase_timer_bit
               if (op_reg == FWS_OP_SECT) etmr_next = now_s.etmr;
               st_next     = FWS_S_RD2;
            end
         end
         FWS_S_RD2: begin
            if (cyc_done) begin
               polls_next  = polls_reg + 32'h0000_0001;
               prev_next   = rdata;
               launch_next = 1'b1;
               // in suspend toggle_bit_one stops; treat stop as done
               if (now_s.tog1 == prev_reg[`FWS_TOG1_BIT]) begin
                  st_next = FWS_S_FINAL;
               end else if (recheck_reg) begin
                  // still toggling after a timeout report: failure, reset
                  fail_next = 1'b1;
                  st_next   = FWS_S_RST;
                  step_next = 3'd0;
               end else if (now_s.tout) begin
                  recheck_next = 1'b1;
               end else if (polls_reg >= POLL_LIMIT - 1) begin
                  // protected sectors only toggle briefly, so this is a hang
                  fail_next = 1'b1;
                  st_next   = FWS_S_RST;
                  step_next = 3'd0;
               end
            end
         end
         FWS_S_FINAL: begin
            // a fresh read after completion gives all sixteen bits valid
            if (cyc_done) begin
               res_next  = rdata;
               done_next = 1'b1;
               st_next   = FWS_S_IDLE;
            end
         end
         FWS_S_RST: begin
            if (cyc_done) begin
               susp_next = 1'b0;
               launch_next = 1'b1;
               st_next   = FWS_S_FINAL;
            end
         end
         default: st_next = FWS_S_IDLE;
      endcase
   end

   // read data mux: answer one cycle after the strobe
   always_comb begin
      rd_out_next = 32'h0000_0000;
      if (sw_rd) begin
         case (sw_addr)
            `FWS_REG_ADDR:   rd_out_next = {8'h00, addr_reg};
            `FWS_REG_DATA:   rd_out_next = {16'h0000, data_reg};
            `FWS_REG_STATUS: rd_out_next = {26'h000_0000, susp_reg, etmr_reg,
                                            ready_busy_n, fail_reg, done_reg, busy_st};
            `FWS_REG_RESULT: rd_out_next = {16'h0000, res_reg};
            default:         rd_out_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_reg      <= FWS_S_IDLE;
         op_reg      <= FWS_OP_PROG;
         step_reg    <= 3'd0;
         addr_reg    <= 24'h00_0000;
         data_reg    <= 16'h0000;
         res_reg     <= 16'h0000;
         prev_reg    <= 16'h0000;
         done_reg    <= 1'b0;
         fail_reg    <= 1'b0;
         recheck_reg <= 1'b0;
         susp_reg    <= 1'b0;
         etmr_reg    <= 1'b0;
         polls_reg   <= 32'h0000_0000;
         launch_reg  <= 1'b0;
         rd_out_reg  <= 32'h0000_0000;
      end else if (ce) begin
         st_reg      <= st_next;
         op_reg      <= op_next;
         step_reg    <= step_next;
         addr_reg    <= addr_next;
         data_reg    <= data_next;
         res_reg     <= res_next;
         prev_reg    <= prev_next;
         done_reg    <= done_next;
         fail_reg    <= fail_next;
         recheck_reg <= recheck_next;
         susp_reg    <= susp_next;
         etmr_reg    <= etmr_next;
         polls_reg   <= polls_next;
         launch_reg  <= launch_next;
         rd_out_reg  <= rd_out_next;
      end
   end
   assign sw_rdata = rd_out_reg;

   // checks
   property p_final_after_stop;
      @(posedge clk) disable iff (!resetn)
         (ce && st_reg == FWS_S_RD2 && cyc_done && now_s.tog1 == prev_reg[`FWS_TOG1_BIT])
         |=> st_reg == FWS_S_FINAL;
   endproperty
   a_final_after_stop: assert property (p_final_after_stop) else $error("no final read");
   property p_fail_reset;
      @(posedge clk) disable iff (!resetn)
         (ce && st_reg == FWS_S_RD2 && cyc_done && recheck_reg &&
          now_s.tog1 != prev_reg[`FWS_TOG1_BIT]) |=> (fail_reg && st_reg == FWS_S_RST);
   endproperty
   a_fail_reset: assert property (p_fail_reset) else $error("no reset on failure");
   property p_recheck;
      @(posedge clk) disable iff (!resetn)
         (ce && st_reg == FWS_S_RD2 && cyc_done && !recheck_reg && now_s.tout &&
          now_s.tog1 != prev_reg[`FWS_TOG1_BIT]) |=> (recheck_reg && st_reg == FWS_S_RD2);
   endproperty
   a_recheck: assert property (p_recheck) else $error("timeout not rechecked");
   property p_poll_addr;
      @(posedge clk) disable iff (!resetn)
         (cyc_start && (st_reg == FWS_S_RD1 || st_reg == FWS_S_RD2)) |-> !cyc.wr && cyc.addr == addr_reg;
   endproperty
   a_poll_addr: assert property (p_poll_addr) else $error("poll at wrong address");
   property p_done_idle;
      @(posedge clk) disable iff (!resetn) $rose(done_reg) |-> st_reg == FWS_S_IDLE;
   endproperty
   a_done_idle: assert property (p_done_idle) else $error("done while busy");
   property p_rst_final;
      @(posedge clk) disable iff (!resetn)
         (ce && st_reg == FWS_S_RST && cyc_done) |=> st_reg == FWS_S_FINAL && !susp_reg;
   endproperty
   a_rst_final: assert property (p_rst_final) else $error("reset not followed by read");
   property p_strobe_excl;
      @(posedge clk) disable iff (!resetn) !(output_enable_n == 1'b0 && write_strobe_n == 1'b0);
   endproperty
   a_strobe_excl: assert property (p_strobe_excl) else $error("read and write strobes together");
   property p_rd_answer;
      @(posedge clk) disable iff (!resetn)
         (ce && sw_rd && sw_addr == `FWS_REG_RESULT) |=> sw_rdata[15:0] == $past(res_reg);
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("bad read data");
   c_done: cover property (@(posedge clk) disable iff (!resetn) $rose(done_reg) && !fail_reg);
   c_fail: cover property (@(posedge clk) disable iff (!resetn) $rose(fail_reg));
   c_susp: cover property (@(posedge clk) disable iff (!resetn) $rose(susp_reg));
endmodule

// ---- sim/fws_flash_model.sv ----
`timescale 1ns/1ps
// behavioural flash: status bits while embedded program or erase runs
module fws_flash_model (
   // bus pins from the host
   input  wire logic        chip_select_n,
   input  wire logic        output_enable_n,
   input  wire logic        write_strobe_n,
   input  wire logic [23:0] flash_addr,
   input  wire logic [15:0] flash_dq_out,
   input  wire logic        flash_dq_oe,
   // test controls: reads until done, forced timeout
   input  wire logic [7:0]  busy_len,
   input  wire logic        fail_mode,
   // resolved lines
   output logic [15:0]      flash_dq_in,
   output logic             ready_busy_n
);
   logic [15:0] mem [16];
   logic [15:0] stat, last, pdata;
   logic [7:0]  left, prev, cmd;
   logic [3:0]  pa;
   logic        busy, prog, sect, susp, tog1, tog2, fail, arm;
   initial begin
      foreach (mem[i]) mem[i] = 16'hFFFF;
      {busy, prog, sect, susp, tog1, tog2, fail, arm, prev, left, last} = '0;
   end
   // command decode at the rising write strobe; status valid from that edge
   // chip select rises in the same step as the strobe, so it is not consulted;
   // only the power-up edge of the strobe is skipped
   always @(posedge write_strobe_n) begin
      if ($time > 0) begin
         cmd = flash_dq_out[7:0];
         if (!busy && prev == 8'hA0) begin
            pa = flash_addr[3:0];
            pdata = flash_dq_out;
            {busy, prog, sect, fail} = {3'h6, fail_mode};
            left = busy_len;
         end else if (cmd == 8'hF0) begin
            {busy, susp, fail, arm} = '0;
         end else if (busy && sect && cmd == 8'hB0) begin
            susp = 1'h1;
         end else if (susp && cmd == 8'h30) begin
            susp = 1'h0;
         end else if (!busy && arm && (cmd == 8'h10 || cmd == 8'h30)) begin
            {busy, prog, sect, arm} = {2'h2, cmd == 8'h30, 1'h0};
            left = busy_len;
         end else if (!busy && cmd == 8'h80) begin
            arm = 1'h1;
         end
         prev = cmd;
      end
   end
   // each finished read while busy flips tog1 (held in suspend) and tog2 (held in program); a stuck op never ends
   always @(posedge output_enable_n) begin
      if ($time > 0) begin
         last = stat;
         if (busy) begin
            tog1 = susp ? tog1 : ~tog1;
            tog2 = prog ? tog2 : ~tog2;
            left = (susp || fail) ? left : left - 8'h01;
            if (left == 8'h00 && !susp && !fail) begin
               busy = 1'h0;
               if (prog) mem[pa] = mem[pa] & pdata;
               else foreach (mem[i]) mem[i] = 16'hFFFF;
            end
         end
      end
   end
   // status word while busy, array data otherwise
   always_comb begin
      stat = mem[flash_addr[3:0]];
      if (busy) begin
         stat[7] = prog ? ~pdata[7] : susp;
         stat[6] = tog1;
         stat[5] = fail;
         stat[3] = sect;
         stat[2] = tog2;
      end
   end
   // a released bus shows the inverse of the last word, never a stale copy
   assign flash_dq_in = flash_dq_oe ? flash_dq_out :
                        (!chip_select_n && !output_enable_n) ? stat : ~last;
   // open drain with pull-up: low only while actively working
   assign ready_busy_n = (busy && !susp) ? 1'h0 : 1'h1;
endmodule

// ---- sim/fws_host_bench.sv ----
`timescale 1ns/1ps
`include "fws_map.svh"
module fws_host_bench;
   import fws_pkg::*;
   logic        clk, resetn, ce, sw_wr, sw_rd, cs_n, oe_n, we_n, dq_oe, rb_n;
   logic        fail_mode, saw_low;
   logic [3:0]  sw_addr;
   logic [31:0] sw_wdata, sw_rdata, st;
   logic [23:0] fa;
   logic [15:0] dq_o, dq_i;
   logic [7:0]  busy_len;
   int          failures, checked;
   fws_host #(.POLL_LIMIT(20)) fws_host_inst (
      .clk(clk), .resetn(resetn), .ce(ce), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .chip_select_n(cs_n),
      .output_enable_n(oe_n), .write_strobe_n(we_n), .flash_addr(fa),
      .flash_dq_out(dq_o), .flash_dq_oe(dq_oe), .flash_dq_in(dq_i), .ready_busy_n(rb_n));
   fws_flash_model fws_flash_model_inst (
      .chip_select_n(cs_n), .output_enable_n(oe_n), .write_strobe_n(we_n),
      .flash_addr(fa), .flash_dq_out(dq_o), .flash_dq_oe(dq_oe), .busy_len(busy_len),
      .fail_mode(fail_mode), .flash_dq_in(dq_i), .ready_busy_n(rb_n));
   // 125 MHz clock
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_wr    <= 1'h1;
      @(posedge clk);
      sw_wr <= 1'h0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_rd   <= 1'h1;
      @(posedge clk);
      sw_rd <= 1'h0;
      #1;
      d = sw_rdata;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // launch one operation, poll status until idle, then compare outcome
   task automatic run_op(input fws_op_e op, input logic [23:0] a, input logic [15:0] d,
                         input logic [31:0] mask, input logic [31:0] exp_st,
                         input logic [15:0] exp_res);
      sw_write(`FWS_REG_ADDR, {8'h00, a});
      sw_write(`FWS_REG_DATA, {16'h0000, d});
      sw_write(`FWS_REG_CTRL, {28'h000_0000, op, 1'h1});
      sw_read(`FWS_REG_STATUS, st);
      check(st & 32'h0000_0001, 32'h0000_0001);
      saw_low = 1'h0;
      for (int i = 0; i < 4000 && st[0] !== 1'h0; i++) begin
         sw_read(`FWS_REG_STATUS, st);
         saw_low |= ~st[3];
      end
      check(st & mask, exp_st);
      sw_read(`FWS_REG_RESULT, st);
      check(st, {16'h0000, exp_res});
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // watchdog well beyond the few thousand cycles the tests need
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      end_of_test();
   end
   initial begin
      {resetn, ce, sw_wr, sw_rd, fail_mode} = 5'h08;
      sw_addr = 4'h0;
      sw_wdata = 32'h0000_0000;
      busy_len = 8'h06;
      repeat (4) @(posedge clk);
      resetn <= 1'h1;
      sw_read(`FWS_REG_STATUS, st);
      check(st & 32'h0000_000F, 32'h0000_0008);
      run_op(FWS_OP_READ, 24'h00_0003, 16'h0000, 32'h0000_001F, 32'h0000_000A, 16'hFFFF);
      run_op(FWS_OP_PROG, 24'h00_0003, 16'h1234, 32'h0000_001F, 32'h0000_000A, 16'h1234);
      check({31'h0000_0000, saw_low}, 32'h0000_0001);
      // forced timeout: toggling never stops, host must reset the device
      fail_mode <= 1'h1;
      run_op(FWS_OP_PROG, 24'h00_0003, 16'h00FF, 32'h0000_0005, 32'h0000_0004, 16'h1234);
      fail_mode <= 1'h0;
      run_op(FWS_OP_SECT, 24'h00_0003, 16'h0000, 32'h0000_001F, 32'h0000_001A, 16'hFFFF);
      check({31'h0000_0000, saw_low}, 32'h0000_0001);
      busy_len <= 8'h01;
      run_op(FWS_OP_PROG, 24'h00_0005, 16'h8001, 32'h0000_001F, 32'h0000_000A, 16'h8001);
      // the device outlasts the compare limit: host gives up and resets it
      busy_len <= 8'h40;
      run_op(FWS_OP_PROG, 24'h00_0006, 16'h00FF, 32'h0000_0005, 32'h0000_0004, 16'hFFFF);
      busy_len <= 8'h0C;
      run_op(FWS_OP_CHIP, 24'h00_0005, 16'h0000, 32'h0000_001F, 32'h0000_000A, 16'hFFFF);
      run_op(FWS_OP_SUSP, 24'h00_0005, 16'h0000, 32'h0000_003F, 32'h0000_002A, 16'hFFFF);
      run_op(FWS_OP_RESUME, 24'h00_0005, 16'h0000, 32'h0000_003F, 32'h0000_000A, 16'hFFFF);
      run_op(FWS_OP_RESET, 24'h00_0005, 16'h0000, 32'h0000_000F, 32'h0000_000A, 16'hFFFF);
      sw_read(4'hF, st);
      check(st, 32'h0000_0000);
      end_of_test();
   end
endmodule
